// ==== src/asrm_pkg.sv ====
/*
 asrm_pkg: constants, timing counts and mode encoding shared by both ends
 of the converter serial readout link.
 assumes: both ends run on a 100 MHz clk_i.
*/
package asrm_pkg;
	localparam int RES_BITS = 16;
	localparam int CLK_PERIOD_NS = 10;
	// conversion time of the modelled converter, plain default
	localparam int CONV_TIME_NS = 1600;
	localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// host wait before readback when no busy indicator is used
	localparam int CONV_MAX_NS = 2000;
	localparam int CONV_MAX_CYC = (CONV_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCK_HALF_CYC = 8;
	localparam int TMR_W = 16;
	localparam int BIT_CNT_W = $clog2(RES_BITS + 1);
	// positions in the synchronised pin vector
	localparam int PIN_SCK = 0;
	localparam int PIN_SDI = 1;
	localparam int PIN_CNV = 2;
	localparam int PIN_N = 3;
	localparam logic LEAD_CS = 1'b0;
	localparam logic LEAD_CHAIN = 1'b1;
	localparam logic SDO_PULL = 1'b1;
	localparam logic [PIN_N-1:0] PIN_RST = 3'h0;
	typedef enum logic [1:0] {
		MODE_CS = 2'b00,
		MODE_CS_BUSY = 2'b01,
		MODE_CHAIN = 2'b10,
		MODE_CHAIN_BUSY = 2'b11
	} asrm_mode_e;
endpackage

// ==== src/asrm_link_if.sv ====
/*
 asrm_link_if: the serial link between host and converter end.
 assumes: sdo has a pull-up; the line reads high while nobody drives it.
*/
`timescale 1ns/1ns
interface asrm_link_if;
	import asrm_pkg::*;
	logic convert_start;
	logic sdi;
	logic sck;
	logic sdo;
	logic sdo_oe;
	logic sdo_line;

	// pull-up resolves the released line
	assign sdo_line = sdo_oe ? sdo : SDO_PULL;

	modport dev (
		input convert_start,
		input sdi,
		input sck,
		output sdo,
		output sdo_oe
	);
	modport host (
		output convert_start,
		output sdi,
		output sck,
		input sdo_line
	);
endinterface

// ==== src/asrm_dev.sv ====
/*
 asrm_dev: converter end of the serial link. mode select at the
 convert_start rising edge, internal conversion timer, 16 bit output
 shift register with optional leading busy bit, daisy chain input.
 assumes: link pins are asynchronous to clk_i; result_i holds the
 converted value when the conversion timer expires.
*/
`timescale 1ns/1ns
// Overview of operation
// RQ1 - sdi high at start: cs mode, sdo released
// RQ2 - host keeps convert_start high through readback
// RQ3 - cs mode, sdi and convert_start low: sdo low
// RQ4 - host returns sdi low early for busy
// RQ5 - cs busy: sdo driven low at conversion end
// RQ6 - result shifted msb first on sck falls
// RQ7 - cs busy: release at 17th fall or sdi rise
// RQ8 - sdi low, sck low at start: chain, no busy
// RQ9 - chain no busy: msb out at conversion end
// RQ10 - chain: sdi shifted in on sck falls
// RQ11 - host gives 16 times n clocks
// RQ12 - sdi low, sck high at start: chain busy
// RQ13 - chain busy: sdo high when conversion done
// RQ14 - host gives 16 times n plus one clocks
// RQ15 - host holds convert_start high in chain modes
// RQ16 - conversion end: acquisition, converter powered down
// RQ17 - chain, sdi and convert_start low: sdo low
// RQ18 - sdi sampled at start picks the mode
// RQ19 - conversion ignores convert_start until done
// RQ20 - 16 bit words, busy bit leads msb
// RQ21 - new start reloads shifter and bit count
module asrm_dev
	import asrm_pkg::*;
#(
	parameter int CONV_CYC_P = CONV_CYC
)(
	input wire logic clk_i,
	input wire logic rstn_i,
	asrm_link_if.dev link,
	input wire logic [RES_BITS-1:0] result_i,
	output logic sample_o,
	output logic converting_o,
	output logic powered_down_o
);

	if (CONV_CYC_P < 1 || CONV_CYC_P >= (1 << TMR_W)) begin : g_bad_conv
		$error("asrm_dev: CONV_CYC_P out of range");
	end

	typedef enum logic [1:0] {
		DS_IDLE = 2'b00,
		DS_CONV = 2'b01,
		DS_READ = 2'b10
	} asrm_dst_e;

	logic [PIN_N-1:0] pin_w;
	logic [PIN_N-1:0] meta_ff;
	logic [PIN_N-1:0] s2_ff;
	logic [PIN_N-1:0] s3_ff;
	logic [PIN_N-1:0] lvl_ff;
	logic [PIN_N-1:0] rise_w;
	logic [PIN_N-1:0] fall_w;
	asrm_dst_e state_ff;
	asrm_mode_e mode_ff;
	logic [TMR_W-1:0] conv_cnt_ff;
	logic [RES_BITS-1:0] shreg_ff;
	logic lead_ff;
	logic [BIT_CNT_W-1:0] bit_cnt_ff;
	logic cs_end_ff;
	logic sdo_ff;
	logic oe_ff;
	logic sample_ff;
	logic nxt_sdo;
	logic nxt_oe;
	logic start_w;
	logic done_w;
	logic busy_end_w;
	logic is_chain_w;
	logic shift_w;
	logic cs_live_w;

	assign pin_w = {link.convert_start, link.sdi, link.sck};

	// three stages; only the last two are compared, first is metastable
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_ff <= PIN_RST;
			s2_ff <= PIN_RST;
			s3_ff <= PIN_RST;
		end else begin
			meta_ff <= pin_w;
			s2_ff <= meta_ff;
			s3_ff <= s2_ff;
		end
	end

	// per pin filter: level moves only when stages two and three agree
	for (genvar i = 0; i < PIN_N; i++) begin : g_pin
		assign rise_w[i] = (s2_ff[i] == s3_ff[i]) & s3_ff[i] & ~lvl_ff[i];
		assign fall_w[i] = (s2_ff[i] == s3_ff[i]) & ~s3_ff[i] & lvl_ff[i];
		always_ff @(posedge clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				lvl_ff[i] <= 1'b0;
			end else if (s2_ff[i] == s3_ff[i]) begin
				lvl_ff[i] <= s3_ff[i];
			end
		end
	end

	// a start during a conversion is dropped
	assign start_w = rise_w[PIN_CNV] & (state_ff != DS_CONV); // RQ19
	assign done_w = (state_ff == DS_CONV) & (conv_cnt_ff == TMR_W'(CONV_CYC_P - 1));
	assign is_chain_w = (mode_ff == MODE_CHAIN) | (mode_ff == MODE_CHAIN_BUSY);
	// cs mode gets its busy bit if either line is low at conversion end
	assign busy_end_w = (mode_ff == MODE_CHAIN_BUSY)
		| ((mode_ff == MODE_CS) & (~lvl_ff[PIN_CNV] | ~lvl_ff[PIN_SDI]));
	// cs mode shifts only while selected
	assign shift_w = (state_ff == DS_READ) & fall_w[PIN_SCK] & (is_chain_w | ~lvl_ff[PIN_SDI]);
	assign cs_live_w = (state_ff == DS_READ) & ~cs_end_ff & (bit_cnt_ff != BIT_CNT_W'(RES_BITS));

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_ff <= DS_IDLE;
		end else begin
			case (state_ff)
				DS_IDLE, DS_READ: begin
					if (start_w) begin
						state_ff <= DS_CONV;
					end
				end
				DS_CONV: begin
					if (done_w) begin
						state_ff <= DS_READ; // RQ16
					end
				end
				default: begin
					state_ff <= DS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			conv_cnt_ff <= '0;
		end else if (start_w) begin
			conv_cnt_ff <= '0;
		end else if (state_ff == DS_CONV) begin
			conv_cnt_ff <= conv_cnt_ff + 1'b1;
		end
	end

	// mode picked from sdi and sck as seen at the start edge
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_ff <= MODE_CS;
		end else if (start_w) begin
			if (lvl_ff[PIN_SDI]) begin
				mode_ff <= MODE_CS; // RQ1 RQ18
			end else if (lvl_ff[PIN_SCK]) begin
				mode_ff <= MODE_CHAIN_BUSY; // RQ12 RQ18
			end else begin
				mode_ff <= MODE_CHAIN; // RQ8 RQ18
			end
		end else if (done_w && busy_end_w && mode_ff == MODE_CS) begin
			mode_ff <= MODE_CS_BUSY;
		end
	end

	// the lead bit is consumed by the first fall without shifting, so an
	// upstream busy bit never lands in this register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lead_ff <= 1'b0;
		end else if (start_w) begin
			lead_ff <= 1'b0;
		end else if (done_w) begin
			lead_ff <= busy_end_w; // RQ20
		end else if (shift_w) begin
			lead_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shreg_ff <= '0;
		end else if (done_w) begin
			shreg_ff <= result_i; // RQ21
		end else if (shift_w && !lead_ff) begin
			shreg_ff <= {shreg_ff[RES_BITS-2:0], is_chain_w & lvl_ff[PIN_SDI]}; // RQ6 RQ10
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bit_cnt_ff <= '0;
		end else if (start_w) begin
			bit_cnt_ff <= '0; // RQ21
		end else if (shift_w && !lead_ff && bit_cnt_ff != BIT_CNT_W'(RES_BITS)) begin
			bit_cnt_ff <= bit_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cs_end_ff <= 1'b0;
		end else if (start_w) begin
			cs_end_ff <= 1'b0;
		end else if (state_ff == DS_READ && rise_w[PIN_SDI] && !is_chain_w) begin
			cs_end_ff <= 1'b1; // RQ7
		end
	end

	always_comb begin
		nxt_oe = 1'b0;
		nxt_sdo = 1'b0;
		if (~lvl_ff[PIN_CNV] & ~lvl_ff[PIN_SDI]) begin
			nxt_oe = 1'b1; // RQ3 RQ17
		end else if (is_chain_w) begin
			// chain output never floats; low while converting
			nxt_oe = 1'b1;
			if (state_ff == DS_READ) begin
				nxt_sdo = lead_ff ? LEAD_CHAIN : shreg_ff[RES_BITS-1]; // RQ9 RQ13
			end
		end else if (cs_live_w & (lead_ff | ~lvl_ff[PIN_SDI])) begin
			nxt_oe = 1'b1; // RQ5 RQ7
			nxt_sdo = lead_ff ? LEAD_CS : shreg_ff[RES_BITS-1]; // RQ6
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sdo_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else begin
			sdo_ff <= nxt_sdo;
			oe_ff <= nxt_oe;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sample_ff <= 1'b0;
		end else begin
			sample_ff <= start_w;
		end
	end

	assign link.sdo = sdo_ff;
	assign link.sdo_oe = oe_ff;
	assign sample_o = sample_ff;
	assign converting_o = (state_ff == DS_CONV);
	assign powered_down_o = (state_ff != DS_CONV); // RQ16

endmodule

// ==== src/asrm_host.sv ====
/*
 asrm_host: host end of the serial link. starts one conversion per
 request in the requested mode, waits for the busy edge or the maximum
 conversion time, then clocks in 16 bits per converter in the chain.
 assumes: sdo reads high when released; sdo is asynchronous to clk_i.
*/
`timescale 1ns/1ns
module asrm_host
	import asrm_pkg::*;
#(
	parameter int N_DEV = 1
)(
	input wire logic clk_i,
	input wire logic rstn_i,
	asrm_link_if.host link,
	input wire logic start_i,
	input wire asrm_mode_e mode_i,
	output logic busy_o,
	output logic done_o,
	output logic [RES_BITS*N_DEV-1:0] data_o
);

	localparam int DW = RES_BITS * N_DEV;
	localparam int REM_W = $clog2(DW + 2);

	if (N_DEV < 1) begin : g_bad_n
		$error("asrm_host: N_DEV must be at least one");
	end

	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_SETUP = 3'b001,
		HS_HOLD = 3'b010,
		HS_WAIT = 3'b011,
		HS_SEL = 3'b100,
		HS_HIGH = 3'b101,
		HS_LOW = 3'b110,
		HS_FIN = 3'b111
	} asrm_hst_e;

	asrm_hst_e st_ff;
	asrm_mode_e mode_ff;
	logic [TMR_W-1:0] tmr_ff;
	logic [REM_W-1:0] rem_ff;
	logic skip_ff;
	logic [DW-1:0] data_ff;
	logic cnv_ff;
	logic sdi_ff;
	logic sck_ff;
	logic done_ff;
	logic meta_ff;
	logic s2_ff;
	logic s3_ff;
	logic sdo_lvl_ff;
	logic half_w;
	logic ready_w;
	logic lead_w;
	logic settle_w;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_ff <= SDO_PULL;
			s2_ff <= SDO_PULL;
			s3_ff <= SDO_PULL;
			sdo_lvl_ff <= SDO_PULL;
		end else begin
			meta_ff <= link.sdo_line;
			s2_ff <= meta_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				sdo_lvl_ff <= s3_ff;
			end
		end
	end

	assign half_w = (tmr_ff == TMR_W'(SCK_HALF_CYC - 1));
	assign lead_w = (mode_ff == MODE_CS_BUSY) | (mode_ff == MODE_CHAIN_BUSY);
	// synchronised sdo lags the line, so right after the start it can still
	// show the previous mode's level; trust the indicator only after a settle
	assign settle_w = (tmr_ff >= TMR_W'(SCK_HALF_CYC));
	// busy modes wait for the indicator edge, others time out
	always_comb begin
		case (mode_ff)
			MODE_CS_BUSY: ready_w = settle_w & ~sdo_lvl_ff;
			MODE_CHAIN_BUSY: ready_w = settle_w & sdo_lvl_ff;
			default: ready_w = (tmr_ff == TMR_W'(CONV_MAX_CYC - 1));
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff <= HS_IDLE;
			mode_ff <= MODE_CS;
			tmr_ff <= '0;
			rem_ff <= '0;
			skip_ff <= 1'b0;
			data_ff <= '0;
			cnv_ff <= 1'b0;
			sdi_ff <= 1'b0;
			sck_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			tmr_ff <= tmr_ff + 1'b1;
			case (st_ff)
				HS_IDLE: begin
					cnv_ff <= 1'b0;
					sdi_ff <= 1'b0;
					sck_ff <= 1'b0;
					tmr_ff <= '0;
					if (start_i) begin
						mode_ff <= mode_i;
						sdi_ff <= (mode_i == MODE_CS) | (mode_i == MODE_CS_BUSY); // RQ1
						sck_ff <= (mode_i == MODE_CHAIN_BUSY); // RQ8 RQ12
						st_ff <= HS_SETUP;
					end
				end
				HS_SETUP: begin
					if (half_w) begin
						cnv_ff <= 1'b1; // RQ2 RQ15
						tmr_ff <= '0;
						st_ff <= HS_HOLD;
					end
				end
				HS_HOLD: begin
					if (half_w) begin
						sck_ff <= 1'b0;
						if (mode_ff == MODE_CS_BUSY) begin
							sdi_ff <= 1'b0; // RQ4
						end
						tmr_ff <= '0;
						st_ff <= HS_WAIT;
					end
				end
				HS_WAIT: begin
					if (ready_w) begin
						rem_ff <= REM_W'(DW) + REM_W'(lead_w); // RQ11 RQ14
						skip_ff <= lead_w;
						tmr_ff <= '0;
						if (mode_ff == MODE_CS) begin
							sdi_ff <= 1'b0;
							st_ff <= HS_SEL;
						end else begin
							sck_ff <= 1'b1;
							st_ff <= HS_HIGH;
						end
					end
				end
				HS_SEL: begin
					if (half_w) begin
						sck_ff <= 1'b1;
						tmr_ff <= '0;
						st_ff <= HS_HIGH;
					end
				end
				HS_HIGH: begin
					// sample just before the fall: the bit stands across both edges
					if (half_w) begin
						if (skip_ff) begin
							skip_ff <= 1'b0;
						end else begin
							data_ff <= {data_ff[DW-2:0], sdo_lvl_ff};
						end
						rem_ff <= rem_ff - 1'b1;
						sck_ff <= 1'b0;
						tmr_ff <= '0;
						st_ff <= HS_LOW;
					end
				end
				HS_LOW: begin
					if (half_w) begin
						tmr_ff <= '0;
						if (rem_ff == '0) begin
							sdi_ff <= (mode_ff == MODE_CS) | (mode_ff == MODE_CS_BUSY);
							st_ff <= HS_FIN;
						end else begin
							sck_ff <= 1'b1;
							st_ff <= HS_HIGH;
						end
					end
				end
				HS_FIN: begin
					// deselect held a half period so the converter sees it
					if (half_w) begin
						done_ff <= 1'b1;
						st_ff <= HS_IDLE;
					end
				end
				default: begin
					st_ff <= HS_IDLE;
				end
			endcase
		end
	end

	assign link.convert_start = cnv_ff;
	assign link.sdi = sdi_ff;
	assign link.sck = sck_ff;
	assign busy_o = (st_ff != HS_IDLE);
	assign done_o = done_ff;
	assign data_o = data_ff;

endmodule

// ==== dv/asrm_link_assertions.sv ====
/*
 asrm_link_chk: concurrent checks on the link wires between host and converter.
 assumes: one converter on the link; clk_i samples every wire.
*/
`timescale 1ns/1ns
module asrm_link_chk
	import asrm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic convert_start,
	input wire logic sdi,
	input wire logic sck,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic sdo_line
);
	logic [5:0] falls_ff;
	logic cs_ff;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// sck falls since the last start, saturating so it never wraps
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			falls_ff <= 6'h00;
		end else if ($rose(convert_start)) begin
			falls_ff <= 6'h00;
		end else if ($fell(sck) && falls_ff != 6'h3F) begin
			falls_ff <= falls_ff + 6'h01;
		end
	end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cs_ff <= 1'b0;
		end else if ($rose(convert_start)) begin
			cs_ff <= sdi;
		end
	end
	a_idle_drive_low: assert property ((!convert_start && !sdi) [*6] |-> sdo_oe && !sdo)
		else $error("sdo not driven low while idle");
	a_chain_start_low: assert property ($rose(convert_start) && !sdi |-> (sdo_oe && !sdo) [*8])
		else $error("chain start did not keep sdo low");
	a_sdi_high_release: assert property ((convert_start && sdi) [*8] |-> !sdo_oe)
		else $error("sdo driven while deselected");
	a_bit_stable: assert property (sck && $past(sck) && sdo_oe && $past(sdo_oe) |-> $stable(sdo))
		else $error("sdo moved while sck high");
	a_shift_on_fall: assert property ($changed(sdo) && sdo_oe && $past(sdo_oe) && convert_start
		&& $past(convert_start) |-> !sck)
		else $error("sdo changed outside sck low");
	a_busy_lead_low: assert property ($rose(sdo_oe) && convert_start && !sdi && !$past(sdi, 8) |-> !sdo)
		else $error("busy lead not low");
	a_release_at_17: assert property (cs_ff && convert_start && $changed(falls_ff) && falls_ff == 6'h11
		|-> ##[0:8] !sdo_oe)
		else $error("sdo not released after 17th fall");
	a_release_holds: assert property ($fell(sdo_oe) && convert_start |-> (!sdo_oe) [*6])
		else $error("released sdo driven again too soon");
	c_cs_start: cover property ($rose(convert_start) && sdi);
	c_chain_start: cover property ($rose(convert_start) && !sdi && !sck);
	c_chain_busy_start: cover property ($rose(convert_start) && !sdi && sck);
	c_busy_edge: cover property ($fell(sdo_line) && convert_start && !sdi);
endmodule

// ==== dv/test_adc_serial_readout_modes.sv ====
/*
 test_adc_serial_readout_modes: host and converter joined on one link; every
 mode read back, conversion length, power-down and back-to-back starts.
 assumes: one converter on the main link, two on a second chained link;
 short conversion count keeps the run brief.
*/
`timescale 1ns/1ns
module test_adc_serial_readout_modes
	import asrm_pkg::*;
;
	localparam int CONV_P = 20;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic start_i = 1'b0;
	asrm_mode_e mode_i = MODE_CS;
	logic [RES_BITS-1:0] result_i = 16'h0000;
	logic sample_o;
	logic converting_o;
	logic powered_down_o;
	logic busy_o;
	logic done_o;
	logic [RES_BITS-1:0] data_o;
	int n_errors = 0;
	int checks_done = 0;
	asrm_link_if asrm_link_if_i ();
	asrm_dev #(.CONV_CYC_P(CONV_P)) asrm_dev_i (.clk_i(clk_i), .rstn_i(rstn_i), .link(asrm_link_if_i.dev),
		.result_i(result_i), .sample_o(sample_o), .converting_o(converting_o), .powered_down_o(powered_down_o));
	asrm_host #(.N_DEV(1)) asrm_host_i (.clk_i(clk_i), .rstn_i(rstn_i), .link(asrm_link_if_i.host),
		.start_i(start_i), .mode_i(mode_i), .busy_o(busy_o), .done_o(done_o), .data_o(data_o));
	asrm_link_chk asrm_link_chk_i (.clk_i(clk_i), .rstn_i(rstn_i), .convert_start(asrm_link_if_i.convert_start),
		.sdi(asrm_link_if_i.sdi), .sck(asrm_link_if_i.sck), .sdo(asrm_link_if_i.sdo),
		.sdo_oe(asrm_link_if_i.sdo_oe), .sdo_line(asrm_link_if_i.sdo_line));
	// two converters chained on a second host: far sdo feeds near sdi
	logic start2_i = 1'b0;
	logic [RES_BITS-1:0] near_v = 16'h0000;
	logic [RES_BITS-1:0] far_v = 16'h0000;
	logic done2_o;
	logic [2*RES_BITS-1:0] data2_o;
	asrm_link_if asrm_link_if_h2_i ();
	asrm_link_if asrm_link_if_near_i ();
	asrm_link_if asrm_link_if_far_i ();
	assign asrm_link_if_near_i.convert_start = asrm_link_if_h2_i.convert_start;
	assign asrm_link_if_near_i.sck = asrm_link_if_h2_i.sck;
	assign asrm_link_if_near_i.sdi = asrm_link_if_far_i.sdo_line;
	assign asrm_link_if_far_i.convert_start = asrm_link_if_h2_i.convert_start;
	assign asrm_link_if_far_i.sck = asrm_link_if_h2_i.sck;
	assign asrm_link_if_far_i.sdi = asrm_link_if_h2_i.sdi;
	assign asrm_link_if_h2_i.sdo = asrm_link_if_near_i.sdo;
	assign asrm_link_if_h2_i.sdo_oe = asrm_link_if_near_i.sdo_oe;
	asrm_dev #(.CONV_CYC_P(CONV_P)) asrm_dev_near_i (.clk_i(clk_i), .rstn_i(rstn_i),
		.link(asrm_link_if_near_i.dev), .result_i(near_v), .sample_o(), .converting_o(), .powered_down_o());
	asrm_dev #(.CONV_CYC_P(CONV_P)) asrm_dev_far_i (.clk_i(clk_i), .rstn_i(rstn_i),
		.link(asrm_link_if_far_i.dev), .result_i(far_v), .sample_o(), .converting_o(), .powered_down_o());
	asrm_host #(.N_DEV(2)) asrm_host_h2_i (.clk_i(clk_i), .rstn_i(rstn_i), .link(asrm_link_if_h2_i.host),
		.start_i(start2_i), .mode_i(mode_i), .busy_o(), .done_o(done2_o), .data_o(data2_o));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic chk(input logic [RES_BITS-1:0] seen, input logic [RES_BITS-1:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic results();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one host request, bounded wait for done
	task automatic run(input asrm_mode_e m, input logic [RES_BITS-1:0] v);
		int i;
		@(negedge clk_i);
		result_i = v;
		mode_i = m;
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		chk(16'(busy_o), 16'h0001, "host busy");
		i = 0;
		while (done_o !== 1'b1 && i < 2000) begin
			@(negedge clk_i);
			i++;
		end
		chk(16'(done_o), 16'h0001, "done");
		chk(data_o, v, "data");
		chk(16'(asrm_link_if_i.convert_start), 16'h0001, "start held");
		chk(16'(busy_o), 16'h0000, "host idle");
	endtask
	task automatic t_idle();
		repeat (8) @(negedge clk_i);
		chk(16'(asrm_link_if_i.sdo_line), 16'h0000, "idle sdo");
		chk(16'(powered_down_o), 16'h0001, "idle power");
	endtask
	task automatic t_modes();
		run(MODE_CS, 16'hA5C3);
		run(MODE_CS_BUSY, 16'h8001);
		run(MODE_CHAIN, 16'h7FFE);
		run(MODE_CHAIN_BUSY, 16'h3C96);
	endtask
	// converting cycles and sample pulses counted across one whole request
	task automatic t_conv();
		int n;
		int s;
		n = 0;
		s = 0;
		fork
			run(MODE_CHAIN, 16'hC001);
			repeat (1500) begin
				@(negedge clk_i);
				n += int'(converting_o === 1'b1);
				s += int'(sample_o === 1'b1);
			end
		join_any
		disable fork;
		chk(16'(n), 16'(CONV_P), "conversion length");
		chk(16'(s), 16'h0001, "sample pulses");
		chk(16'({powered_down_o, converting_o}), 16'h0002, "power down");
	endtask
	// no gap between requests: stale shifter or count would show
	task automatic t_b2b();
		run(MODE_CS_BUSY, 16'hFFFF);
		run(MODE_CHAIN_BUSY, 16'h0000);
		run(MODE_CS, 16'h0001);
		run(MODE_CHAIN, 16'hFFFF);
	endtask
	// near word first, then the far word that followed it through the near shifter
	task automatic t_chain2(input asrm_mode_e m, input logic [RES_BITS-1:0] near, input logic [RES_BITS-1:0] far);
		int i;
		@(negedge clk_i);
		near_v = near;
		far_v = far;
		mode_i = m;
		start2_i = 1'b1;
		@(negedge clk_i);
		start2_i = 1'b0;
		i = 0;
		while (done2_o !== 1'b1 && i < 2000) begin
			@(negedge clk_i);
			i++;
		end
		chk(16'(done2_o), 16'h0001, "chain done");
		chk(data2_o[2*RES_BITS-1:RES_BITS], near, "near word");
		chk(data2_o[RES_BITS-1:0], far, "far word");
	endtask
	initial begin
		repeat (2) @(negedge clk_i);
		rstn_i = 1'b1;
		t_idle();
		t_modes();
		t_conv();
		t_b2b();
		t_chain2(MODE_CHAIN, 16'hA5C3, 16'h3C96);
		t_chain2(MODE_CHAIN_BUSY, 16'h8001, 16'hFFFE);
		results();
	end
	// about a dozen requests of some 450 cycles each, with wide margin
	initial begin
		#200000;
		n_errors++;
		results();
	end
endmodule
